// *** ied_pkg.sv ***
// constants for the interrupt enable and dispatch block
// assumes a 32-bit apb slave port with word-aligned registers
package ied_pkg;
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          NUM_SRC       = 18;
    // register indices; the byte address is four times the index
    localparam logic [9:0]  IDX_EN_A      = 10'h0a8;
    localparam logic [9:0]  IDX_EN_B      = 10'h0b8;
    localparam logic [9:0]  IDX_EN_C      = 10'h09a;
    localparam logic [9:0]  IDX_FLAGS     = 10'h100;
    localparam logic [9:0]  IDX_PRIO      = 10'h101;
    localparam logic [9:0]  IDX_STATUS    = 10'h102;
    localparam logic [9:0]  IDX_MASK      = 10'h103;
    localparam logic [9:0]  IDX_ACTIVE    = 10'h104;
    // enable register fields
    localparam int          GLOBAL_EN_BIT = 7;
    localparam logic [7:0]  EN_A_WMASK    = 8'hbf;
    localparam logic [7:0]  EN_BC_WMASK   = 8'h3f;
    localparam logic [7:0]  EN_RESET      = 8'h00;
    // source numbers with paired flag bits
    localparam int          SRC_CIPHER    = 4;
    localparam int          SRC_RADIO_GEN = 16;
    // flags register: 17:0 one flag per source (4 and 16 read as the OR of their pair), 19:18 cipher pair, 21:20 radio pair
    localparam int          CIPHER_PAIR_LO = 18;
    localparam int          RADIO_PAIR_LO  = 20;
    // vector address = base + stride * source
    localparam logic [7:0]  VEC_BASE      = 8'h03;
    localparam int          VEC_SHIFT     = 3;
    // instruction cycles spent on the forced call after detection
    localparam logic [2:0]  CALL_CYCLES   = 3'h6;
    // status bits
    localparam int          ST_CALL       = 0;
    localparam int          ST_RETURN     = 1;
    localparam int          ST_W          = 2;

    typedef enum logic [1:0] {
        IED_IDLE = 2'b01,
        IED_CALL = 2'b10
    } ied_state_t;
endpackage

// *** ied_dispatch.sv ***
// interrupt enable registers, source flags, priority pick and forced-call dispatch
// assumes instr_cycle pulses once per instruction cycle of the core and
// return_from_service pulses when the core executes the return instruction
`timescale 1ns/10ps
`default_nettype none
module ied_dispatch
    import ied_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [NUM_SRC-1:0]  src_event,
    input  wire logic                cipher_event,
    input  wire logic                radio_gen_event,
    input  wire logic                instr_cycle,
    input  wire logic                return_from_service,
    output logic                     forced_long_call,
    output logic                     call_done,
    output logic      [7:0]          call_vector,
    output logic                     irq
);
    logic [7:0]          en_a_q, en_b_q, en_c_q;
    logic [NUM_SRC-1:0]  flag_q, prio_q;
    logic [1:0]          cipher_pair_q, radio_pair_q;
    logic [ST_W-1:0]     status_q, mask_q;
    logic [1:0]          active_q;
    ied_state_t          state_q;
    logic [2:0]          cnt_q;
    logic [4:0]          src_q;
    logic                prio_sel_q;
    logic [31:0]         prdata_q;
    logic                pready_q, pslverr_q, call_q, done_q, irq_q;
    logic [7:0]          vector_q;

    logic [9:0]          idx;
    logic                wr_en, rd_en, mapped;
    logic [31:0]         rd_val;
    logic [NUM_SRC-1:0]  en_vec, pend, req, req_hi, pick_set;
    logic                pick_ok, pick_hi;
    logic [4:0]          pick_src;
    logic                call_fin;

    assign idx   = paddr[11:2];
    assign wr_en = psel && penable && pready_q && pwrite;
    assign rd_en = psel && penable && !pready_q && !pwrite;

    // per-source enable vector by source number
    always_comb begin
        en_vec     = '0;
        en_vec[0]  = en_a_q[0];
        en_vec[1]  = en_a_q[1];
        en_vec[2]  = en_a_q[2];
        en_vec[3]  = en_a_q[3];
        en_vec[4]  = en_a_q[4];
        en_vec[5]  = en_a_q[5];
        en_vec[8]  = en_b_q[0];
        en_vec[9]  = en_b_q[1];
        en_vec[10] = en_b_q[2];
        en_vec[11] = en_b_q[3];
        en_vec[12] = en_b_q[4];
        en_vec[13] = en_b_q[5];
        en_vec[16] = en_c_q[0];
        en_vec[6]  = en_c_q[1];
        en_vec[7]  = en_c_q[2];
        en_vec[14] = en_c_q[3];
        en_vec[15] = en_c_q[4];
        en_vec[17] = en_c_q[5];
    end

    always_comb begin
        pend                = flag_q;
        pend[SRC_CIPHER]    = |cipher_pair_q;
        pend[SRC_RADIO_GEN] = |radio_pair_q;
        req    = pend & en_vec & {NUM_SRC{en_a_q[GLOBAL_EN_BIT]}};
        req_hi = req & prio_q;
    end

    // pick: high level first, only levels above the active service qualify
    always_comb begin
        pick_hi = |req_hi;
        if (active_q[1]) begin
            pick_set = '0;
        end else if (active_q[0]) begin
            pick_set = req_hi;
        end else if (pick_hi) begin
            pick_set = req_hi;
        end else begin
            pick_set = req;
        end
        pick_ok  = |pick_set;
        pick_src = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pick_set[i]) begin
                pick_src = 5'(i);
            end
        end
    end

    assign call_fin = (state_q == IED_CALL) && instr_cycle && (cnt_q == 3'h1);

    // dispatch sequence counted in instruction cycles
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q    <= IED_IDLE;
            cnt_q      <= 3'h0;
            src_q      <= 5'h00;
            prio_sel_q <= 1'b0;
            call_q     <= 1'b0;
            done_q     <= 1'b0;
            vector_q   <= 8'h00;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                IED_IDLE: begin
                    if (instr_cycle && pick_ok) begin
                        state_q    <= IED_CALL;
                        cnt_q      <= CALL_CYCLES;
                        src_q      <= pick_src;
                        prio_sel_q <= prio_q[pick_src];
                        call_q     <= 1'b1;
                        vector_q   <= VEC_BASE + {pick_src, 3'h0};
                    end
                end
                IED_CALL: begin
                    if (instr_cycle) begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                    if (call_fin) begin
                        state_q <= IED_IDLE;
                        call_q  <= 1'b0;
                        done_q  <= 1'b1;
                    end
                end
                default: begin
                    state_q <= IED_IDLE;
                    call_q  <= 1'b0;
                end
            endcase
        end
    end

    // active service levels: bit1 high, bit0 low
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            active_q <= 2'b00;
        end else if (call_fin) begin
            active_q[prio_sel_q] <= 1'b1;
        end else if (return_from_service) begin
            if (active_q[1]) begin
                active_q[1] <= 1'b0;
            end else begin
                active_q[0] <= 1'b0;
            end
        end
    end

    // source flags: set wins over any clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flag_q        <= '0;
            cipher_pair_q <= 2'b00;
            radio_pair_q  <= 2'b00;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (src_event[i] && i != SRC_CIPHER && i != SRC_RADIO_GEN) begin
                    flag_q[i] <= 1'b1;
                end else if (i != SRC_CIPHER && i != SRC_RADIO_GEN &&
                             ((call_fin && src_q == 5'(i)) ||
                              (wr_en && idx == IDX_FLAGS && pwdata[i]))) begin
                    flag_q[i] <= 1'b0;
                end else if (i == SRC_CIPHER || i == SRC_RADIO_GEN) begin
                    flag_q[i] <= 1'b0;
                end
            end
            for (int j = 0; j < 2; j++) begin
                if (cipher_event) begin
                    cipher_pair_q[j] <= 1'b1;
                end else if (wr_en && idx == IDX_FLAGS && pwdata[CIPHER_PAIR_LO + j]) begin
                    cipher_pair_q[j] <= 1'b0;
                end
                if (radio_gen_event) begin
                    radio_pair_q[j] <= 1'b1;
                end else if (wr_en && idx == IDX_FLAGS && pwdata[RADIO_PAIR_LO + j]) begin
                    radio_pair_q[j] <= 1'b0;
                end
            end
        end
    end

    // software registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            en_a_q <= EN_RESET;
            en_b_q <= EN_RESET;
            en_c_q <= EN_RESET;
            prio_q <= '0;
            mask_q <= '0;
        end else if (wr_en) begin
            case (idx)
                IDX_EN_A:   en_a_q <= pwdata[7:0] & EN_A_WMASK;
                IDX_EN_B:   en_b_q <= pwdata[7:0] & EN_BC_WMASK;
                IDX_EN_C:   en_c_q <= pwdata[7:0] & EN_BC_WMASK;
                IDX_PRIO:   prio_q <= pwdata[NUM_SRC-1:0];
                IDX_MASK:   mask_q <= pwdata[ST_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // sticky event status, write one to clear, set wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            for (int k = 0; k < ST_W; k++) begin
                if ((k == ST_CALL && call_fin) || (k == ST_RETURN && return_from_service)) begin
                    status_q[k] <= 1'b1;
                end else if (wr_en && idx == IDX_STATUS && pwdata[k]) begin
                    status_q[k] <= 1'b0;
                end
            end
            irq_q <= |(status_q & mask_q);
        end
    end

    // read mux and decode
    always_comb begin
        mapped = 1'b1;
        rd_val = '0;
        case (idx)
            IDX_EN_A:   rd_val[7:0] = en_a_q;
            IDX_EN_B:   rd_val[7:0] = en_b_q;
            IDX_EN_C:   rd_val[7:0] = en_c_q;
            IDX_FLAGS:  rd_val[RADIO_PAIR_LO+1:0] = {radio_pair_q, cipher_pair_q, pend};
            IDX_PRIO:   rd_val[NUM_SRC-1:0] = prio_q;
            IDX_STATUS: rd_val[ST_W-1:0] = status_q;
            IDX_MASK:   rd_val[ST_W-1:0] = mask_q;
            IDX_ACTIVE: rd_val[1:0] = active_q;
            default:    mapped = 1'b0;
        endcase
    end

    // apb: one wait state, answer on the second access-phase edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            if (rd_en) begin
                prdata_q <= rd_val;
            end
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign forced_long_call = call_q;
    assign call_done        = done_q;
    assign call_vector      = vector_q;
    assign irq              = irq_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    no_ack_disabled_a: assert property (
        (state_q == IED_IDLE && instr_cycle && !en_a_q[GLOBAL_EN_BIT]) |=> !call_q)
        else $error("call started with global enable clear");
    unused_zero_a: assert property (
        !en_a_q[6] && en_b_q[7:6] == 2'b00 && en_c_q[7:6] == 2'b00)
        else $error("unused enable bit set");
    vector_value_a: assert property (
        $rose(call_q) |-> vector_q == VEC_BASE + {src_q, 3'h0})
        else $error("vector does not match source");
    no_equal_preempt_a: assert property (
        (active_q[1] && state_q == IED_IDLE) |=> state_q == IED_IDLE)
        else $error("preempted highest active level");
    return_level_a: assert property (
        (return_from_service && !call_fin && active_q == 2'b11) |=> active_q == 2'b01)
        else $error("return did not drop the high level");
    flag_sets_a: assert property (
        src_event[0] |=> flag_q[0])
        else $error("event did not set its flag");
    ack_next_cycle_a: assert property (
        (state_q == IED_IDLE && instr_cycle && pick_ok) |=> call_q)
        else $error("enabled request not acknowledged");
    call_length_a: assert property (
        $rose(call_q) |-> cnt_q == CALL_CYCLES)
        else $error("forced call not six instruction cycles");
    flag_autoclear_a: assert property (
        (call_fin && src_q == 5'h00 && !src_event[0]) |=> !flag_q[0])
        else $error("flag not cleared on vectoring");
    pair_request_a: assert property (
        cipher_event |=> pend[SRC_CIPHER] && cipher_pair_q == 2'b11)
        else $error("cipher pair not set");
    lowest_wins_a: assert property (
        (state_q == IED_IDLE && instr_cycle && req[0] && req[1] && prio_q[1:0] == 2'b00
         && active_q == 2'b00 && !(|req_hi)) |=> src_q == 5'h00)
        else $error("lowest source did not win");
endmodule
`default_nettype wire

// *** ied_core_model.sv ***
// behavioural core model: instruction-cycle strobe and return instruction
// assumes the bench pulses ret_req for one clock to end a service routine
`timescale 1ns/10ps
`default_nettype none
module ied_core_model (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic slow,
    input  wire logic ret_req,
    output logic      instr_cycle,
    output logic      return_from_service
);
    logic [1:0] cnt_q;
    logic       ret_q;
    // slow mode spaces instruction cycles three clocks apart
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= 2'h0;
            instr_cycle <= 1'b0;
        end else begin
            cnt_q <= (cnt_q != 2'h0) ? cnt_q - 2'h1 : (slow ? 2'h2 : 2'h0);
            instr_cycle <= (cnt_q == 2'h0);
        end
    end
    // the return executes on the next instruction cycle of the core
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ret_q <= 1'b0;
            return_from_service <= 1'b0;
        end else begin
            ret_q <= ret_req | (ret_q & (cnt_q != 2'h0));
            return_from_service <= ret_q & (cnt_q == 2'h0);
        end
    end
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the interrupt enable and dispatch block
// assumes the core model drives instruction strobes and return pulses
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ied_pkg::*;
    localparam int grp_tab [NUM_SRC] = '{0,0,0,0,0,0,2,2,1,1,1,1,1,1,2,2,2,2};
    localparam int bit_tab [NUM_SRC] = '{0,1,2,3,4,5,1,2,0,1,2,3,4,5,3,4,0,5};
    localparam logic [9:0] en_idx [3] = '{IDX_EN_A, IDX_EN_B, IDX_EN_C};
    logic               sys_clk = 1'b0;
    logic               sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata;
    logic [NUM_SRC-1:0] src_event;
    logic               cipher_event, radio_gen_event, instr_cycle, return_from_service;
    logic               forced_long_call, call_done, irq, slow, ret_req, last_err;
    logic [7:0]         call_vector;
    int                 fail_count = 0;
    int                 tests_run = 0;

    always #12.5 sys_clk = ~sys_clk;

    ied_dispatch i_ied_dispatch (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event),
        .cipher_event(cipher_event), .radio_gen_event(radio_gen_event),
        .instr_cycle(instr_cycle), .return_from_service(return_from_service),
        .forced_long_call(forced_long_call), .call_done(call_done),
        .call_vector(call_vector), .irq(irq));
    ied_core_model i_ied_core_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow),
        .ret_req(ret_req), .instr_cycle(instr_cycle),
        .return_from_service(return_from_service));

    task automatic finish_test();
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [9:0] idx, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] q;
        apb(idx, 1'b1, d, q);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] e);
        logic [31:0] q;
        apb(idx, 1'b0, 32'h0, q);
        chk(q, e);
    endtask

    task automatic fire(input logic [NUM_SRC-1:0] m);
        @(posedge sys_clk);
        src_event <= m;
        cipher_event <= m[SRC_CIPHER];
        radio_gen_event <= m[SRC_RADIO_GEN];
        @(posedge sys_clk);
        src_event <= '0;
        cipher_event <= 1'b0;
        radio_gen_event <= 1'b0;
    endtask

    // waits for a forced call and counts the instruction cycles it spends
    task automatic take(input int src);
        int k;
        int c;
        k = 0;
        c = 0;
        @(negedge sys_clk);
        while (forced_long_call !== 1'b1 && k < 100) begin
            @(negedge sys_clk);
            k++;
        end
        while (call_done !== 1'b1 && k < 200) begin
            if (instr_cycle === 1'b1) c++;
            @(negedge sys_clk);
            k++;
        end
        chk({24'h0, call_vector}, 32'(VEC_BASE) + 32'(src * 8));
        chk(32'(c), 32'h6);
    endtask

    task automatic no_call(input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(negedge sys_clk);
            if (forced_long_call !== 1'b0) bad = 1'b1;
        end
        chk({31'h0, bad}, 32'h0);
    endtask

    task automatic ret();
        int k;
        k = 0;
        @(posedge sys_clk);
        ret_req <= 1'b1;
        @(posedge sys_clk);
        ret_req <= 1'b0;
        while (return_from_service !== 1'b1 && k < 20) begin
            @(negedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        finish_test();
    end

    initial begin
        logic [31:0] e;
        sys_rst = 1'b1;
        {psel, penable, pwrite, cipher_event, radio_gen_event, slow, ret_req} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        src_event = '0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int n = 0; n < NUM_SRC; n++) begin
            for (int g = 0; g < 3; g++) begin
                e = (g == grp_tab[n]) ? 32'h1 << bit_tab[n] : 32'h0;
                if (g == 0) e[GLOBAL_EN_BIT] = 1'b1;
                wr(en_idx[g], e);
            end
            e = (32'h1 << bit_tab[n]) | ((grp_tab[n] == 0) ? 32'h80 : 32'h0);
            rd(en_idx[grp_tab[n]], e);
            fire(NUM_SRC'(1) << n);
            take(n);
            e = (n == 4) ? 32'h000c_0010 : (n == 16) ? 32'h0031_0000 : 32'h0;
            rd(IDX_FLAGS, e);
            wr(IDX_FLAGS, 32'hffff_ffff);
            ret();
            rd(IDX_ACTIVE, 32'h0);
        end
        wr(IDX_EN_A, 32'h3f);
        wr(IDX_EN_B, 32'h0);
        fire(18'h204);
        no_call(20);
        rd(IDX_FLAGS, 32'h204);
        wr(IDX_EN_A, 32'hbf);
        take(2);
        ret();
        no_call(10);
        wr(IDX_EN_B, 32'h3f);
        take(9);
        ret();
        @(posedge sys_clk);
        slow <= 1'b1;
        fire(18'h208);
        take(3);
        no_call(20);
        wr(IDX_PRIO, 32'h1000);
        fire(18'h1000);
        take(12);
        rd(IDX_ACTIVE, 32'h3);
        ret();
        no_call(20);
        ret();
        take(9);
        ret();
        rd(IDX_STATUS, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_MASK, 32'h1);
        repeat (2) @(negedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_STATUS, 32'h1);
        repeat (2) @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        rd(IDX_STATUS, 32'h2);
        for (int g = 0; g < 3; g++) begin
            wr(en_idx[g], 32'hffff_ffff);
            rd(en_idx[g], (g == 0) ? 32'hbf : 32'h3f);
        end
        fire(18'h003);
        take(0);
        no_call(10);
        ret();
        take(1);
        ret();
        rd(10'h200, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        chk({30'h0, forced_long_call, irq}, 32'h0);
        for (int g = 0; g < 3; g++) rd(en_idx[g], 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
